// file: src/alu_status_flags.sv
/*
 * Arithmetic flag register of the 8-bit core with its own flag arithmetic.
 * Each cycle with opValid high executes one instruction: operands come
 * from the datapath, the result and the new flags go back registered.
 * The register is read and written as an ordinary file register through
 * the file read/write ports; opDestIsFlags marks the flag register as the
 * destination of the executing instruction.
 * Assumes the datapath holds opCode and the operands steady through the
 * rising edge at which opValid is high, and maps a literal operand onto
 * operandFile. The flags reset to zero here, although software should
 * treat them as unknown until it has written them.
 */
//
// How it works
// - negative flag bit 4 copies result bit 7, except on clear, which keeps it.
// - overflow flag bit 3 set when signed result sign is wrong.
// - zero flag bit 2 set when the operation result is zero.
// - rotates load the nibble carry flag from source bit 4 or 3.
// - add and subtract set carry bit 0 on carry-out of bit 7.
// - subtraction adds the complement, so carries act as inverted borrow.
// - flag-affecting ops aimed at the flags update flags, not result.
// - clearing the flag register sets only the zero flag.
// - bit set/clear, swap and moves change no flag, write data directly.
// - the flag register reads and writes like any other file register.
`timescale 1ns/10ps
`include "alu_status_flags_params.svh"

module alu_status_flags (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic opValid,
    input wire alu_status_flags_pkg::alu_op_t opCode,
    input wire logic [7:0] operandFile,
    input wire logic [7:0] operandAcc,
    input wire logic [2:0] bitSelect,
    input wire logic opDestIsFlags,
    input wire logic fileWrite,
    input wire logic [7:0] fileWriteData,
    output logic [7:0] arithmetic_flags,
    output logic [7:0] aluResult,
    output logic aluResultValid
);
    import alu_status_flags_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // operation decode

    logic [4:0] flags;
    wire isAdd = (opCode == OP_ADD_ACC_TO_FILE) || (opCode == OP_ADD_LITERAL_TO_ACC);
    wire isSub = (opCode == OP_SUBTRACT_ACC_FROM_LITERAL)
        || (opCode == OP_SUBTRACT_ACC_FROM_FILE);
    wire isArith = isAdd || isSub;
    wire isRotate = (opCode == OP_ROTATE_RIGHT) || (opCode == OP_ROTATE_LEFT);
    wire isLogic = opCode == OP_LOGIC;
    wire isClear = opCode == OP_CLEAR_FILE_REGISTER;
    wire isNoFlag = (opCode == OP_BIT_CLEAR) || (opCode == OP_BIT_SET)
        || (opCode == OP_NIBBLE_SWAP) || (opCode == OP_FILE_TO_FILE_MOVE)
        || (opCode == OP_ACC_TO_FILE_MOVE);
    wire affectsFlags = isArith || isRotate || isLogic || isClear;

    ////////////////////////////////////////////////////////////////////////
    // arithmetic

    wire [7:0] addendB = isSub ? ~operandAcc : operandAcc;
    wire carryIn = isSub;
    wire [4:0] lowSum = {1'b0, operandFile[3:0]} + {1'b0, addendB[3:0]}
        + {4'h0, carryIn};
    wire [8:0] fullSum = {1'b0, operandFile} + {1'b0, addendB} + {8'h00, carryIn};
    wire [7:0] sumValue = fullSum[7:0];
    // sign wrong when operands agree and result differs
    wire signedOvf = (operandFile[7] == addendB[7]) && (sumValue[7] != operandFile[7]);

    ////////////////////////////////////////////////////////////////////////
    // result selection

    wire [7:0] bitMask = 8'h01 << bitSelect;
    wire [7:0] rotRight = {flags[`FLAG_CARRY_BIT], operandFile[7:1]};
    wire [7:0] rotLeft = {operandFile[6:0], flags[`FLAG_CARRY_BIT]};
    logic [7:0] opResult;
    always_comb begin
        case (opCode)
            OP_ADD_ACC_TO_FILE, OP_ADD_LITERAL_TO_ACC,
            OP_SUBTRACT_ACC_FROM_LITERAL, OP_SUBTRACT_ACC_FROM_FILE: opResult = sumValue;
            OP_LOGIC: opResult = operandFile;
            OP_ROTATE_RIGHT: opResult = rotRight;
            OP_ROTATE_LEFT: opResult = rotLeft;
            OP_CLEAR_FILE_REGISTER: opResult = 8'h00;
            OP_BIT_CLEAR: opResult = operandFile & ~bitMask;
            OP_BIT_SET: opResult = operandFile | bitMask;
            OP_NIBBLE_SWAP: opResult = {operandFile[3:0], operandFile[7:4]};
            OP_FILE_TO_FILE_MOVE: opResult = operandFile;
            OP_ACC_TO_FILE_MOVE: opResult = operandAcc;
            default: opResult = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // flag sources

    // one candidate per flag source; the priority further down picks among them
    wire flagUpdate = opValid && affectsFlags;
    wire directWrite = opValid && isNoFlag && opDestIsFlags;
    wire rotIsRight = opCode == OP_ROTATE_RIGHT;
    wire negFromResult = opResult[7];
    wire zeroFromResult = opResult == 8'h00;
    wire carryFromSum = fullSum[8];
    wire nibbleFromSum = lowSum[4];
    wire carryFromRotate = rotIsRight ? operandFile[0] : operandFile[7];
    // nibble carry from bit 4 or 3
    wire nibbleFromRotate = rotIsRight ? operandFile[4] : operandFile[3];
    wire [4:0] directFlags = opResult[4:0];
    // plain file register write, upper bits dropped
    wire [4:0] fileFlags = fileWriteData[4:0];
    // flag-affecting result not written back when aimed at flags
    wire resultDropped = affectsFlags && opDestIsFlags;

    ////////////////////////////////////////////////////////////////////////
    // per-flag next values

    logic next_neg;
    logic next_ovf;
    logic next_zero;
    logic next_nibble;
    logic next_carry;
    always_comb begin
        // clear keeps negative, result zero sets zero
        next_neg = flags[`FLAG_NEG_BIT];
        if (flagUpdate && !isClear) begin
            next_neg = negFromResult;
        end
        next_zero = flags[`FLAG_ZERO_BIT];
        if (flagUpdate) begin
            next_zero = zeroFromResult;
        end
        // overflow only means something for add and subtract
        next_ovf = flags[`FLAG_OVF_BIT];
        if (flagUpdate && isArith) begin
            next_ovf = signedOvf;
        end
        next_carry = flags[`FLAG_CARRY_BIT];
        if (flagUpdate && isArith) begin
            next_carry = carryFromSum;
        end else if (flagUpdate && isRotate) begin
            next_carry = carryFromRotate;
        end
        next_nibble = flags[`FLAG_NIBBLE_BIT];
        if (flagUpdate && isArith) begin
            next_nibble = nibbleFromSum;
        end else if (flagUpdate && isRotate) begin
            next_nibble = nibbleFromRotate;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write priority

    // an executing op outranks a plain file write in the same cycle
    logic [4:0] next_flags;
    always_comb begin
        next_flags = {next_neg, next_ovf, next_zero, next_nibble, next_carry};
        if (directWrite) begin
            next_flags = directFlags;
        end else if (fileWrite && !flagUpdate) begin
            next_flags = fileFlags;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flags <= `FLAG_RESET_VALUE;
        end else begin
            flags <= next_flags;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            aluResult <= 8'h00;
        end else begin
            aluResult <= opResult;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            aluResultValid <= 1'b0;
        end else begin
            aluResultValid <= opValid && !resultDropped;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            arithmetic_flags <= 8'h00;
        end else begin
            arithmetic_flags <= {3'b000, next_flags} & `FLAG_IMPL_MASK;
        end
    end

endmodule

// file: src/alu_status_flags_params.svh
/*
 * Bit positions, implemented mask and reset value of the arithmetic flag register.
 * Assumes inclusion from the flag register module.
 */
`ifndef ALU_STATUS_FLAGS_PARAMS_SVH
`define ALU_STATUS_FLAGS_PARAMS_SVH

`define FLAG_CARRY_BIT 0
`define FLAG_NIBBLE_BIT 1
`define FLAG_ZERO_BIT 2
`define FLAG_OVF_BIT 3
`define FLAG_NEG_BIT 4
`define FLAG_IMPL_MASK 8'h1f
`define FLAG_RESET_VALUE 5'h00

`endif

// file: src/alu_status_flags_pkg.sv
/*
 * Types shared by the flag register and its bench: the operation codes
 * that the execution datapath presents with each instruction.
 */
package alu_status_flags_pkg;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_ADD_ACC_TO_FILE = 4'h1,
        OP_ADD_LITERAL_TO_ACC = 4'h2,
        OP_SUBTRACT_ACC_FROM_LITERAL = 4'h3,
        OP_SUBTRACT_ACC_FROM_FILE = 4'h4,
        OP_LOGIC = 4'h5,
        OP_ROTATE_RIGHT = 4'h6,
        OP_ROTATE_LEFT = 4'h7,
        OP_CLEAR_FILE_REGISTER = 4'h8,
        OP_BIT_CLEAR = 4'h9,
        OP_BIT_SET = 4'ha,
        OP_NIBBLE_SWAP = 4'hb,
        OP_FILE_TO_FILE_MOVE = 4'hc,
        OP_ACC_TO_FILE_MOVE = 4'hd
    } alu_op_t;

endpackage

// file: sim/alu_status_flags_sva.sv
/* flag register checker; assumes one clock and synchronous reset */
`timescale 1ns/10ps
module alu_status_flags_sva (
    input wire logic sys_clk, srst, opValid, opDestIsFlags, aluResultValid,
    input wire alu_status_flags_pkg::alu_op_t opCode,
    input wire logic [7:0] operandFile, operandAcc, arithmetic_flags, aluResult
);
    import alu_status_flags_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    wire isAdd = opValid && (opCode == OP_ADD_ACC_TO_FILE || opCode == OP_ADD_LITERAL_TO_ACC);
    wire isSub = opValid && opCode == OP_SUBTRACT_ACC_FROM_FILE;
    wire isClr = opValid && opCode == OP_CLEAR_FILE_REGISTER && opDestIsFlags;
    a_upper_zero:
    assert property (arithmetic_flags[7:5] == 3'h0) else $error("upper bits set");
    a_neg_msb:
    assert property (isAdd |=> arithmetic_flags[4] == aluResult[7]) else $error("neg wrong");
    a_zero_result:
    assert property (isAdd |=> arithmetic_flags[2] == (aluResult == 8'h00)) else $error("zero");
    a_add_carry:
    assert property (isAdd |=> arithmetic_flags[0] ==
        ({1'h0, $past(operandFile)} + $past(operandAcc) > 9'h0ff)) else $error("carry");
    a_sub_borrow:
    assert property (isSub |=> arithmetic_flags[0] == ($past(operandFile) >= $past(operandAcc)))
        else $error("borrow");
    a_rot_carry:
    assert property (opValid && opCode == OP_ROTATE_LEFT |=>
        arithmetic_flags[0] == $past(operandFile[7])) else $error("rotate carry");
    a_dest_hold:
    assert property (isAdd && opDestIsFlags |=> !aluResultValid) else $error("writeback");
    a_clear_zero:
    assert property (isClr |=> arithmetic_flags == {3'h0, $past(arithmetic_flags[4:3]), 1'h1,
        $past(arithmetic_flags[1:0])}) else $error("clear");
endmodule
bind alu_status_flags alu_status_flags_sva chk (.sys_clk(sys_clk), .srst(srst),
    .opValid(opValid), .opDestIsFlags(opDestIsFlags), .aluResultValid(aluResultValid),
    .opCode(opCode), .operandFile(operandFile), .operandAcc(operandAcc),
    .arithmetic_flags(arithmetic_flags), .aluResult(aluResult));

// file: sim/exec_model.sv
/* datapath model: one instruction per call; assumes a free-running clock */
`timescale 1ns/10ps
module exec_model (
    input wire logic sys_clk,
    output alu_status_flags_pkg::alu_op_t opCode,
    output logic opValid,
    output logic [7:0] operandFile,
    output logic [7:0] operandAcc,
    output logic [2:0] bitSelect,
    output logic opDestIsFlags
);
    import alu_status_flags_pkg::*;
    initial opCode = OP_NONE;
    initial {opValid, operandFile, operandAcc, bitSelect, opDestIsFlags} = '0;
    task automatic issue(input alu_op_t op, input logic [7:0] f, a, input logic [2:0] b,
        input logic d);
        @(negedge sys_clk);
        opCode = op;
        {operandFile, operandAcc, bitSelect, opDestIsFlags, opValid} = {f, a, b, d, 1'h1};
        @(negedge sys_clk);
        // operands turn stale once the op is gone
        {operandFile, operandAcc, opValid} = {~f, ~a, 1'h0};
    endtask
endmodule

// file: sim/tb.sv
/* self-checking bench of the flag register; the datapath model issues ops */
`timescale 1ns/10ps
module tb;
    import alu_status_flags_pkg::*;
    logic sys_clk = 1'h0, srst = 1'h1, fileWrite = 1'h0;
    logic opValid, opDestIsFlags, aluResultValid;
    logic [7:0] fileWriteData = 8'h00, operandFile, operandAcc, arithmetic_flags, aluResult;
    logic [2:0] bitSelect;
    alu_op_t opCode;
    int n_fail = 0, num_checks = 0;
    always #12.5 sys_clk = ~sys_clk;
    exec_model dp (.sys_clk(sys_clk), .opCode(opCode), .opValid(opValid),
        .operandFile(operandFile), .operandAcc(operandAcc), .bitSelect(bitSelect),
        .opDestIsFlags(opDestIsFlags));
    alu_status_flags dut (.sys_clk(sys_clk), .srst(srst), .opValid(opValid), .opCode(opCode),
        .operandFile(operandFile), .operandAcc(operandAcc), .bitSelect(bitSelect),
        .opDestIsFlags(opDestIsFlags), .fileWrite(fileWrite), .fileWriteData(fileWriteData),
        .arithmetic_flags(arithmetic_flags), .aluResult(aluResult),
        .aluResultValid(aluResultValid));
    task automatic chk(input string name, input logic [7:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wrap_up;
        if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic t_arith;
        alu_op_t ad [2] = '{OP_ADD_ACC_TO_FILE, OP_ADD_LITERAL_TO_ACC};
        alu_op_t sb [2] = '{OP_SUBTRACT_ACC_FROM_FILE, OP_SUBTRACT_ACC_FROM_LITERAL};
        foreach (ad[i]) begin
            dp.issue(ad[i], 8'h7f, 8'h01, 3'h0, 1'h0);
            chk("sum", 8'h80, aluResult);
            chk("addflags", 8'h1a, arithmetic_flags);
            dp.issue(ad[i], 8'hff, 8'h01, 3'h0, 1'h0);
            chk("wrapflags", 8'h07, arithmetic_flags);
            dp.issue(sb[i], 8'h05, 8'h03, 3'h0, 1'h0);
            chk("subflags", 8'h03, arithmetic_flags);
            dp.issue(sb[i], 8'h03, 8'h05, 3'h0, 1'h0);
            chk("borrowflags", 8'h10, arithmetic_flags);
        end
    endtask
    task automatic t_rotate;
        dp.issue(OP_ROTATE_RIGHT, 8'h19, 8'h00, 3'h0, 1'h0);
        chk("rr", 8'h0c, aluResult);
        chk("rrflags", 8'h03, {6'h0, arithmetic_flags[1:0]});
        dp.issue(OP_ROTATE_LEFT, 8'h80, 8'h00, 3'h0, 1'h0);
        chk("rl", 8'h01, aluResult);
        chk("rlflags", 8'h01, {6'h0, arithmetic_flags[1:0]});
    endtask
    task automatic t_dest;
        @(negedge sys_clk);
        {fileWrite, fileWriteData} = {1'h1, 8'hff};
        @(negedge sys_clk);
        {fileWrite, fileWriteData} = {1'h0, 8'h00};
        chk("write", 8'h1f, arithmetic_flags);
        dp.issue(OP_ADD_ACC_TO_FILE, 8'h7f, 8'h01, 3'h0, 1'h1);
        chk("wb", 8'h00, {7'h0, aluResultValid});
        chk("dflags", 8'h1a, arithmetic_flags);
        dp.issue(OP_CLEAR_FILE_REGISTER, 8'h00, 8'h00, 3'h0, 1'h1);
        chk("clr", 8'h1e, arithmetic_flags);
        dp.issue(OP_BIT_SET, 8'h1e, 8'h00, 3'h7, 1'h1);
        chk("bset", 8'h1e, arithmetic_flags);
        dp.issue(OP_BIT_CLEAR, 8'h1e, 8'h00, 3'h2, 1'h1);
        chk("bclr", 8'h1a, arithmetic_flags);
        dp.issue(OP_FILE_TO_FILE_MOVE, 8'he5, 8'h00, 3'h0, 1'h1);
        chk("move", 8'h05, arithmetic_flags);
        dp.issue(OP_LOGIC, 8'h80, 8'h00, 3'h0, 1'h0);
        chk("lneg", 8'h11, arithmetic_flags);
        chk("lwb", 8'h01, {7'h0, aluResultValid});
        dp.issue(OP_LOGIC, 8'h00, 8'h00, 3'h0, 1'h0);
        chk("lzero", 8'h05, arithmetic_flags);
    endtask
    initial begin
        #100000;
        n_fail++;
        wrap_up;
    end
    initial begin
        repeat (10) @(negedge sys_clk);
        srst = 1'h0;
        chk("reset", 8'h00, arithmetic_flags);
        t_arith;
        t_rotate;
        t_dest;
        wrap_up;
    end
endmodule
